// File: rtl/usrsr_consts.svh
`ifndef USRSR_CONSTS_SVH
`define USRSR_CONSTS_SVH
// ****************************************
// character timing
// ****************************************
`define USRSR_CLK_HZ        40000000
`define USRSR_BAUD          9600
`define USRSR_BIT_CYC       (`USRSR_CLK_HZ / `USRSR_BAUD)
`define USRSR_DATA_BITS     8
// ****************************************
// frame bytes
// ****************************************
`define USRSR_UART_HDR      8'hFF
`define USRSR_HDR_HI        8'h55
`define USRSR_HDR_LO        8'hAA
`define USRSR_OP_ALL        8'h01
`define USRSR_OP_ADDR       8'h03
`define USRSR_OP_ONE_BASE   8'h10
`define USRSR_OP_ONE_LAST   8'h13
`define USRSR_BCAST_ADDR    8'hFF
`define USRSR_ADDR_RESET    8'h01
`define USRSR_UART_PKT_LEN  10
// ****************************************
// timing in ms and derived cycles
// ****************************************
`define USRSR_CYCLE_MS      300
`define USRSR_ALL_DLY_MS    205
`define USRSR_ONE_DLY_MS    70
`define USRSR_ALL_GAP_MS    250
`define USRSR_ONE_GAP_MS    90
`define USRSR_MS_CYC        (`USRSR_CLK_HZ / 1000)
`endif

// File: rtl/usrsr_pkg.sv
package usrsr_pkg;
    typedef enum logic [1:0] {USRSR_MODE_UART, USRSR_MODE_BUS} usrsr_mode_t;
    typedef logic [15:0] usrsr_dist_t;
endpackage

// File: rtl/usrsr_link_if.sv
`timescale 1ns/10ps
// one-wire serial link; the bench resolves the shared line from the enables
interface usrsr_link_if;
    logic dev_line_o;
    logic dev_line_oe;
    logic host_line_o;
    logic host_line_oe;
    logic line_i;
    modport device (output dev_line_o, output dev_line_oe, input line_i);
    modport host   (output host_line_o, output host_line_oe, input line_i);
endinterface

// File: rtl/usrsr_device.sv
`timescale 1ns/10ps
`include "usrsr_consts.svh"
module usrsr_device
    import usrsr_pkg::*;
#(
    parameter int CYCLE_CYC   = `USRSR_CYCLE_MS * `USRSR_MS_CYC,
    parameter int ALL_DLY_CYC = `USRSR_ALL_DLY_MS * `USRSR_MS_CYC,
    parameter int ONE_DLY_CYC = `USRSR_ONE_DLY_MS * `USRSR_MS_CYC,
    parameter int BIT_CYC     = `USRSR_BIT_CYC
)(
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        bus_mode_i,
    input  wire usrsr_dist_t dist_i [4],
    usrsr_link_if.device     link,
    output logic             busy_o,
    output logic [7:0]       slave_addr_o
);
    // ****************************************
    // receive side, two-flop synchroniser
    // ****************************************
    logic        rx_meta_reg;
    logic        rx_sync_reg;
    logic        rx_act_reg;
    logic [15:0] rx_cnt_reg;
    logic [3:0]  rx_bit_reg;
    logic [7:0]  rx_sh_reg;
    logic        rx_stb;
    logic [2:0]  rx_idx_reg;
    logic [7:0]  rx_addr_reg;
    logic [7:0]  rx_op_reg;
    logic [7:0]  rx_sum_reg;
    logic        mode_reg;
    wire         rx_live = mode_reg & ~busy_o;

    always_ff @(posedge core_clk_i)
    begin
        rx_meta_reg <= link.line_i;
        rx_sync_reg <= rx_meta_reg;
    end

    // one start, eight data, one stop, sampled mid-bit
    wire rx_half = rx_cnt_reg == 16'(BIT_CYC / 2);
    wire rx_end  = rx_cnt_reg == 16'(BIT_CYC - 1);
    assign rx_stb = rx_act_reg & rx_end & (rx_bit_reg == 4'h9);

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i || !rx_live)
        begin
            rx_act_reg <= 1'b0;
            rx_cnt_reg <= 16'h0000;
            rx_bit_reg <= 4'h0;
            rx_sh_reg  <= 8'h00;
        end
        else if (!rx_act_reg)
        begin
            rx_act_reg <= ~rx_sync_reg;
            rx_cnt_reg <= 16'h0000;
            rx_bit_reg <= 4'h0;
        end
        else
        begin
            rx_cnt_reg <= rx_end ? 16'h0000 : rx_cnt_reg + 16'h0001;
            if (rx_end)
                rx_bit_reg <= rx_bit_reg + 4'h1;
            if (rx_half && rx_bit_reg >= 4'h1 && rx_bit_reg <= 4'h8)
                rx_sh_reg <= {rx_sync_reg, rx_sh_reg[7:1]};
            if (rx_stb)
                rx_act_reg <= 1'b0;
            if (rx_half && rx_bit_reg == 4'h0 && rx_sync_reg)
                rx_act_reg <= 1'b0; // false start bit
        end
    end

    // ****************************************
    // command frame parser
    // ****************************************
    wire [7:0] rx_sum_next = rx_sum_reg + rx_sh_reg;
    wire hdr_ok = (rx_idx_reg == 3'd0 && rx_sh_reg == `USRSR_HDR_HI)
               || (rx_idx_reg == 3'd1 && rx_sh_reg == `USRSR_HDR_LO);
    wire addr_ok = rx_addr_reg == slave_addr_o
                || rx_addr_reg == `USRSR_BCAST_ADDR;
    wire op_one  = rx_op_reg >= `USRSR_OP_ONE_BASE
                && rx_op_reg <= `USRSR_OP_ONE_LAST;
    wire op_known = rx_op_reg == `USRSR_OP_ALL || op_one
                 || rx_op_reg == `USRSR_OP_ADDR;
    wire is_addr_cmd = rx_op_reg == `USRSR_OP_ADDR;
    wire cmd_ok = rx_stb && rx_idx_reg == 3'd4 && rx_sh_reg == rx_sum_reg
               && op_known && (addr_ok || is_addr_cmd);

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i || !rx_live)
        begin
            rx_idx_reg  <= 3'd0;
            rx_sum_reg  <= 8'h00;
            rx_addr_reg <= 8'h00;
            rx_op_reg   <= 8'h00;
        end
        else if (rx_stb)
        begin
            if (rx_idx_reg <= 3'd1 && !hdr_ok)
            begin
                rx_idx_reg <= (rx_sh_reg == `USRSR_HDR_HI) ? 3'd1 : 3'd0;
                rx_sum_reg <= (rx_sh_reg == `USRSR_HDR_HI) ? rx_sh_reg : 8'h00;
            end
            else if (rx_idx_reg == 3'd4)
            begin
                rx_idx_reg <= 3'd0;
                rx_sum_reg <= 8'h00;
            end
            else
            begin
                rx_idx_reg <= rx_idx_reg + 3'd1;
                rx_sum_reg <= rx_sum_next;
                if (rx_idx_reg == 3'd2)
                    rx_addr_reg <= rx_sh_reg;
                if (rx_idx_reg == 3'd3)
                    rx_op_reg <= rx_sh_reg;
            end
        end
    end

    // ****************************************
    // sequencer: delay, then load reply bytes
    // ****************************************
    typedef enum logic [1:0] {USRSR_IDLE, USRSR_WAIT, USRSR_SEND} usrsr_st_t;
    usrsr_st_t   st_reg;
    logic [31:0] tmr_reg;
    logic [3:0]  byte_idx_reg;
    logic [3:0]  byte_cnt_reg;
    logic [7:0]  op_reg;
    logic [7:0]  echo_reg;
    logic [7:0]  sum_reg;
    logic [7:0]  pkt [14];
    logic        buf_ready;
    logic        tx_done;

    // distances pass through unsigned, high byte first
    wire [7:0] one_hi = dist_i[op_reg[1:0]][15:8];
    wire [7:0] one_lo = dist_i[op_reg[1:0]][7:0];
    always_comb
    begin
        for (int i = 0; i < 14; i++)
            pkt[i] = 8'h00;
        if (!mode_reg)
        begin
            pkt[0] = `USRSR_UART_HDR;
            for (int i = 0; i < 4; i++)
            begin
                pkt[1 + 2 * i] = dist_i[i][15:8];
                pkt[2 + 2 * i] = dist_i[i][7:0];
            end
        end
        else
        begin
            pkt[0] = `USRSR_HDR_HI;
            pkt[1] = `USRSR_HDR_LO;
            pkt[2] = echo_reg; // broadcast echoes 0xFF
            pkt[3] = op_reg;
            if (op_reg == `USRSR_OP_ALL)
                for (int i = 0; i < 4; i++)
                begin
                    pkt[4 + 2 * i] = dist_i[i][15:8];
                    pkt[5 + 2 * i] = dist_i[i][7:0];
                end
            else if (op_reg != `USRSR_OP_ADDR)
            begin
                pkt[4] = one_hi;
                pkt[5] = one_lo;
            end
        end
    end
    wire last_byte = byte_idx_reg == byte_cnt_reg - 4'd1;
    wire [7:0] cur_byte = last_byte ? sum_reg : pkt[byte_idx_reg];
    wire       push = st_reg == USRSR_SEND && buf_ready;
    wire [3:0] rsp_len = (rx_op_reg == `USRSR_OP_ALL) ? 4'd13
                       : op_one ? 4'd7 : 4'd5;

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            st_reg       <= USRSR_IDLE;
            tmr_reg      <= 32'h0;
            byte_idx_reg <= 4'h0;
            byte_cnt_reg <= 4'h0;
            op_reg       <= 8'h00;
            echo_reg     <= 8'h00;
            sum_reg      <= 8'h00;
            busy_o       <= 1'b0;
            slave_addr_o <= `USRSR_ADDR_RESET;
            mode_reg     <= 1'b0;
        end
        else
        begin
            case (st_reg)
                USRSR_IDLE:
                begin
                    mode_reg <= bus_mode_i; // mode latched between frames
                    tmr_reg  <= tmr_reg + 32'h1;
                    if (!mode_reg && tmr_reg >= 32'(CYCLE_CYC - 1))
                    begin
                        st_reg       <= USRSR_SEND;
                        byte_cnt_reg <= 4'(`USRSR_UART_PKT_LEN);
                        byte_idx_reg <= 4'h0;
                        sum_reg      <= 8'h00;
                        tmr_reg      <= 32'h0;
                    end
                    else if (mode_reg && cmd_ok)
                    begin
                        st_reg       <= USRSR_WAIT;
                        busy_o       <= 1'b1;
                        op_reg       <= rx_op_reg;
                        echo_reg     <= rx_addr_reg;
                        byte_cnt_reg <= rsp_len;
                        tmr_reg      <= 32'h0;
                        if (is_addr_cmd)
                            slave_addr_o <= rx_addr_reg;
                    end
                end
                USRSR_WAIT:
                begin
                    tmr_reg <= tmr_reg + 32'h1;
                    if ((op_reg == `USRSR_OP_ALL
                         && tmr_reg >= 32'(ALL_DLY_CYC - 1))
                        || (op_reg != `USRSR_OP_ALL
                         && tmr_reg >= 32'(ONE_DLY_CYC - 1)))
                    begin
                        st_reg       <= USRSR_SEND;
                        byte_idx_reg <= 4'h0;
                        sum_reg      <= 8'h00;
                    end
                end
                USRSR_SEND:
                begin
                    tmr_reg <= tmr_reg + 32'h1;
                    if (push)
                    begin
                        sum_reg      <= sum_reg + cur_byte;
                        byte_idx_reg <= byte_idx_reg + 4'h1;
                    end
                    if (byte_idx_reg == byte_cnt_reg && tx_done)
                    begin
                        st_reg <= USRSR_IDLE;
                        busy_o <= 1'b0;
                    end
                end
                default: st_reg <= USRSR_IDLE;
            endcase
        end
    end

    // ****************************************
    // two-entry buffer and transmitter
    // ****************************************
    logic [7:0] fifo_q [2];
    logic [1:0] fifo_cnt_reg;
    logic       wr_ptr_reg;
    logic       rd_ptr_reg;
    logic       tx_act_reg;
    logic [15:0] tx_cnt_reg;
    logic [3:0] tx_bit_reg;
    logic [9:0] tx_sh_reg;
    assign buf_ready = fifo_cnt_reg != 2'd2 && byte_idx_reg != byte_cnt_reg;
    wire fifo_valid = fifo_cnt_reg != 2'd0;
    wire pop = fifo_valid && !tx_act_reg;
    assign tx_done = !fifo_valid && !tx_act_reg;
    wire tx_end = tx_cnt_reg == 16'(BIT_CYC - 1);

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            fifo_cnt_reg <= 2'd0;
            wr_ptr_reg   <= 1'b0;
            rd_ptr_reg   <= 1'b0;
            fifo_q[0]    <= 8'h00;
            fifo_q[1]    <= 8'h00;
            tx_act_reg   <= 1'b0;
            tx_cnt_reg   <= 16'h0000;
            tx_bit_reg   <= 4'h0;
            tx_sh_reg    <= 10'h3FF;
        end
        else
        begin
            if (push)
            begin
                fifo_q[wr_ptr_reg] <= cur_byte;
                wr_ptr_reg         <= ~wr_ptr_reg;
            end
            fifo_cnt_reg <= fifo_cnt_reg + 2'(push) - 2'(pop);
            if (pop) // stop, data lsb first, start
            begin
                rd_ptr_reg <= ~rd_ptr_reg;
                tx_sh_reg  <= {1'b1, fifo_q[rd_ptr_reg], 1'b0};
                tx_act_reg <= 1'b1;
                tx_cnt_reg <= 16'h0000;
                tx_bit_reg <= 4'h0;
            end
            else if (tx_act_reg)
            begin
                tx_cnt_reg <= tx_end ? 16'h0000 : tx_cnt_reg + 16'h0001;
                if (tx_end)
                begin
                    tx_sh_reg  <= {1'b1, tx_sh_reg[9:1]};
                    tx_bit_reg <= tx_bit_reg + 4'h1;
                    if (tx_bit_reg == 4'h9)
                        tx_act_reg <= 1'b0;
                end
            end
        end
    end

    // bus mode drives only while a reply is going out
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            link.dev_line_o  <= 1'b1;
            link.dev_line_oe <= 1'b0;
        end
        else
        begin
            link.dev_line_o  <= tx_sh_reg[0];
            link.dev_line_oe <= !mode_reg || st_reg == USRSR_SEND;
        end
    end
endmodule

// File: rtl/usrsr_host.sv
`timescale 1ns/10ps
`include "usrsr_consts.svh"
// bus master: sends one command frame, collects the reply bytes
module usrsr_host
    import usrsr_pkg::*;
#(
    parameter int BIT_CYC = `USRSR_BIT_CYC
)(
    input  wire logic       core_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       cmd_valid_i,
    input  wire logic [7:0] cmd_addr_i,
    input  wire logic [7:0] cmd_op_i,
    usrsr_link_if.host      link,
    output logic            cmd_ready_o,
    output logic            rx_valid_o,
    output logic [7:0]      rx_data_o
);
    // ****************************************
    // transmitter
    // ****************************************
    logic [2:0]  idx_reg;
    logic [7:0]  addr_reg;
    logic [7:0]  op_reg;
    logic [7:0]  sum_reg;
    logic        act_reg;
    logic [15:0] cnt_reg;
    logic [3:0]  bit_reg;
    logic [9:0]  sh_reg;
    wire         tx_end = cnt_reg == 16'(BIT_CYC - 1);
    wire [7:0]   cur = idx_reg == 3'd0 ? `USRSR_HDR_HI
                     : idx_reg == 3'd1 ? `USRSR_HDR_LO
                     : idx_reg == 3'd2 ? addr_reg
                     : idx_reg == 3'd3 ? op_reg : sum_reg;
    // spacing of commands (250/90 ms) is the caller's duty

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            idx_reg     <= 3'd0;
            addr_reg    <= 8'h00;
            op_reg      <= 8'h00;
            sum_reg     <= 8'h00;
            act_reg     <= 1'b0;
            cnt_reg     <= 16'h0000;
            bit_reg     <= 4'h0;
            sh_reg      <= 10'h3FF;
            cmd_ready_o <= 1'b1;
        end
        else if (cmd_ready_o)
        begin
            if (cmd_valid_i)
            begin
                cmd_ready_o <= 1'b0;
                addr_reg    <= cmd_addr_i;
                op_reg      <= cmd_op_i;
                sum_reg     <= `USRSR_HDR_HI + `USRSR_HDR_LO
                             + cmd_addr_i + cmd_op_i;
                idx_reg     <= 3'd0;
            end
        end
        else if (!act_reg)
        begin
            if (idx_reg == 3'd5)
                cmd_ready_o <= 1'b1;
            else
            begin
                sh_reg  <= {1'b1, cur, 1'b0};
                act_reg <= 1'b1;
                cnt_reg <= 16'h0000;
                bit_reg <= 4'h0;
                idx_reg <= idx_reg + 3'd1;
            end
        end
        else
        begin
            cnt_reg <= tx_end ? 16'h0000 : cnt_reg + 16'h0001;
            if (tx_end)
            begin
                sh_reg  <= {1'b1, sh_reg[9:1]};
                bit_reg <= bit_reg + 4'h1;
                if (bit_reg == 4'h9)
                    act_reg <= 1'b0;
            end
        end
    end

    // line released once the frame is out
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            link.host_line_o  <= 1'b1;
            link.host_line_oe <= 1'b0;
        end
        else
        begin
            link.host_line_o  <= sh_reg[0];
            link.host_line_oe <= !cmd_ready_o;
        end
    end

    // ****************************************
    // receiver for replies
    // ****************************************
    logic        m_reg;
    logic        s_reg;
    logic        ra_reg;
    logic [15:0] rc_reg;
    logic [3:0]  rb_reg;
    logic [7:0]  rs_reg;
    wire         r_half = rc_reg == 16'(BIT_CYC / 2);
    wire         r_end  = rc_reg == 16'(BIT_CYC - 1);
    always_ff @(posedge core_clk_i)
    begin
        m_reg <= link.line_i;
        s_reg <= m_reg;
    end
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i || !cmd_ready_o)
        begin
            ra_reg     <= 1'b0;
            rc_reg     <= 16'h0000;
            rb_reg     <= 4'h0;
            rs_reg     <= 8'h00;
            rx_valid_o <= 1'b0;
            rx_data_o  <= 8'h00;
        end
        else
        begin
            rx_valid_o <= 1'b0;
            if (!ra_reg)
            begin
                ra_reg <= ~s_reg;
                rc_reg <= 16'h0000;
                rb_reg <= 4'h0;
            end
            else
            begin
                rc_reg <= r_end ? 16'h0000 : rc_reg + 16'h0001;
                if (r_end)
                    rb_reg <= rb_reg + 4'h1;
                if (r_half && rb_reg >= 4'h1 && rb_reg <= 4'h8)
                    rs_reg <= {s_reg, rs_reg[7:1]};
                if (r_end && rb_reg == 4'h9)
                begin
                    ra_reg     <= 1'b0;
                    rx_valid_o <= 1'b1;
                    rx_data_o  <= rs_reg;
                end
            end
        end
    end
endmodule

// File: verif/usrsr_props.sv
`timescale 1ns/10ps
`include "usrsr_consts.svh"
// ********
// wire checks on the shared link
// ********
module usrsr_props
#(
    parameter int BIT_CYC = `USRSR_BIT_CYC
)(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic dev_line_o,
    input wire logic dev_line_oe,
    input wire logic host_line_o,
    input wire logic host_line_oe,
    input wire logic line_i
);
    int dev_low;
    int host_low;

    // low run lengths; a rise must end a whole number of bit times
    always_ff @(posedge core_clk_i)
    begin
        dev_low  <= (!rst_n_i || dev_line_o) ? 0 : dev_low + 1;
        host_low <= (!rst_n_i || host_line_o) ? 0 : host_low + 1;
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_one_talker;
        !(dev_line_oe && host_line_oe);
    endproperty
    a_one_talker: assert property (p_one_talker)
        else $error("both ends drive the line");

    property p_dev_release;
        $fell(dev_line_oe) |-> $past(dev_line_o);
    endproperty
    a_dev_release: assert property (p_dev_release)
        else $error("device released line before stop level");

    property p_host_release;
        $fell(host_line_oe) |-> $past(host_line_o);
    endproperty
    a_host_release: assert property (p_host_release)
        else $error("host released line before stop level");

    property p_dev_bits;
        $rose(dev_line_o) && dev_line_oe
            |-> (dev_low % BIT_CYC == 0) && (dev_low <= 9 * BIT_CYC);
    endproperty
    a_dev_bits: assert property (p_dev_bits)
        else $error("device low run not whole bit times");

    property p_host_bits;
        $rose(host_line_o) && host_line_oe
            |-> (host_low % BIT_CYC == 0) && (host_low <= 9 * BIT_CYC);
    endproperty
    a_host_bits: assert property (p_host_bits)
        else $error("host low run not whole bit times");

    property p_dev_hold;
        $rose(dev_line_oe) |=> dev_line_oe [*8];
    endproperty
    a_dev_hold: assert property (p_dev_hold)
        else $error("device drive shorter than a character");

    property p_host_hold;
        $rose(host_line_oe) |=> host_line_oe [*8];
    endproperty
    a_host_hold: assert property (p_host_hold)
        else $error("host drive shorter than a character");

    property p_cmd_quiet;
        $fell(host_line_oe) |-> !dev_line_oe [*8];
    endproperty
    a_cmd_quiet: assert property (p_cmd_quiet)
        else $error("device answered with no delay");

    c_dev_reply: cover property ($rose(dev_line_oe));
    c_host_cmd: cover property ($rose(host_line_oe));
    c_host_low: cover property (!line_i && host_line_oe);
endmodule

// File: verif/tb_ultrasonic_range_serial_reporter.sv
`timescale 1ns/10ps
module tb_ultrasonic_range_serial_reporter
    import usrsr_pkg::*;
;
    // ********
    // short counts keep the run brief
    // ********
    localparam int BIT  = 16;
    localparam int CYC  = 2000;
    localparam int ALLD = 1000;
    localparam int ONED = 400;
    logic        core_clk_i  = 1'b0;
    logic        rst_n_i     = 1'b0;
    logic        bus_mode_i  = 1'b0;
    logic        cmd_valid_i = 1'b0;
    logic [7:0]  cmd_addr_i  = 8'h00;
    logic [7:0]  cmd_op_i    = 8'h00;
    usrsr_dist_t dist_i [4]  = '{16'h03E8, 16'h07D0, 16'h07A1, 16'h0DEA};
    logic        busy_o;
    logic [7:0]  slave_addr_o;
    logic        cmd_ready_o;
    logic        rx_valid_o;
    logic [7:0]  rx_data_o;
    logic [7:0]  dq[$];
    logic [7:0]  hq[$];
    logic [7:0]  eq[$];
    logic [7:0]  wb;
    logic [7:0]  na;
    int          cyc = 0;
    int          t_first;
    int          t_cmd;
    int          err_total = 0;
    int          checks = 0;
    usrsr_link_if link ();

    // pull-up idle; a clash shows as unknown
    assign link.line_i = (link.dev_line_oe === 1'b1) ?
        ((link.host_line_oe === 1'b1) ? 1'bx : link.dev_line_o) :
        ((link.host_line_oe === 1'b1) ? link.host_line_o : 1'b1);

    always #12.5 core_clk_i = ~core_clk_i;

    usrsr_device #(.CYCLE_CYC(CYC), .ALL_DLY_CYC(ALLD),
        .ONE_DLY_CYC(ONED), .BIT_CYC(BIT)) u_usrsr_device (
        .core_clk_i   (core_clk_i),
        .rst_n_i      (rst_n_i),
        .bus_mode_i   (bus_mode_i),
        .dist_i       (dist_i),
        .link         (link.device),
        .busy_o       (busy_o),
        .slave_addr_o (slave_addr_o)
    );
    usrsr_host #(.BIT_CYC(BIT)) u_usrsr_host (
        .core_clk_i  (core_clk_i),
        .rst_n_i     (rst_n_i),
        .cmd_valid_i (cmd_valid_i),
        .cmd_addr_i  (cmd_addr_i),
        .cmd_op_i    (cmd_op_i),
        .link        (link.host),
        .cmd_ready_o (cmd_ready_o),
        .rx_valid_o  (rx_valid_o),
        .rx_data_o   (rx_data_o)
    );
    usrsr_props #(.BIT_CYC(BIT)) u_usrsr_props (
        .core_clk_i   (core_clk_i),
        .rst_n_i      (rst_n_i),
        .dev_line_o   (link.dev_line_o),
        .dev_line_oe  (link.dev_line_oe),
        .host_line_o  (link.host_line_o),
        .host_line_oe (link.host_line_oe),
        .line_i       (link.line_i)
    );

    // ********
    // helpers
    // ********
    task automatic complete_run();
        if (err_total == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    always @(posedge core_clk_i)
    begin
        cyc <= cyc + 1;
        if (rx_valid_o === 1'b1)
            hq.push_back(rx_data_o);
        if (cyc == 60000)
        begin
            err_total++;
            complete_run();
        end
    end

    // device bytes straight off the wire, sampled mid-bit
    always
    begin
        @(negedge link.line_i);
        if (link.dev_line_oe === 1'b1)
        begin
            if (dq.size() == 0)
                t_first = cyc;
            repeat (BIT / 2) @(posedge core_clk_i);
            for (int i = 0; i < 8; i++)
            begin
                repeat (BIT) @(posedge core_clk_i);
                wb[i] = link.line_i;
            end
            repeat (BIT) @(posedge core_clk_i);
            check(16'(link.line_i), 16'h0001);
            dq.push_back(wb);
        end
    end

    task automatic build(input logic uart, input logic [7:0] adr,
                         input logic [7:0] op);
        logic [7:0] s;
        eq.delete();
        if (uart)
            eq.push_back(8'hFF);
        else
            eq = '{8'h55, 8'hAA, adr, op};
        for (int k = 0; k < 4; k++)
            if (uart || op == 8'h01 || op == 8'(16 + k))
            begin
                eq.push_back(dist_i[k][15:8]);
                eq.push_back(dist_i[k][7:0]);
            end
        s = 8'h00;
        foreach (eq[j])
            s += eq[j];
        eq.push_back(s);
    endtask

    task automatic wait_q(ref logic [7:0] q[$], input int n, input int lim);
        int w;
        w = 0;
        while (q.size() < n && w < lim)
        begin
            @(posedge core_clk_i);
            w++;
        end
    endtask

    task automatic cmp_q(ref logic [7:0] q[$]);
        check(16'(q.size()), 16'(eq.size()));
        foreach (q[j])
            if (j < eq.size())
                check({8'h00, q[j]}, {8'h00, eq[j]});
    endtask

    task automatic set_dist(input usrsr_dist_t a, input usrsr_dist_t b);
        @(posedge core_clk_i);
        dist_i[0] <= a;
        dist_i[1] <= b;
        dist_i[2] <= usrsr_dist_t'($urandom);
        dist_i[3] <= usrsr_dist_t'($urandom);
        @(posedge core_clk_i);
    endtask

    task automatic wait_rdy();
        int w;
        w = 0;
        while (cmd_ready_o !== 1'b1 && w < 4000)
        begin
            @(posedge core_clk_i);
            w++;
        end
    endtask

    task automatic send_cmd(input logic [7:0] adr, input logic [7:0] op);
        wait_rdy();
        cmd_addr_i  <= adr;
        cmd_op_i    <= op;
        cmd_valid_i <= 1'b1;
        @(posedge core_clk_i);
        cmd_valid_i <= 1'b0;
        @(posedge core_clk_i);
        wait_rdy();
        t_cmd = cyc;
    endtask

    // dly 0 means no reply is allowed
    task automatic txn(input logic [7:0] adr, input logic [7:0] op,
                       input logic [7:0] radr, input int dly);
        int lat;
        int tol;
        dq.delete();
        hq.delete();
        send_cmd(adr, op);
        build(1'b0, radr, op);
        if (dly == 0)
            eq.delete();
        repeat (BIT) @(posedge core_clk_i);
        check(16'(busy_o), 16'(dly != 0));
        wait_q(dq, eq.size() == 0 ? 1 : eq.size(), ALLD + 3000);
        repeat (2 * BIT) @(posedge core_clk_i);
        cmp_q(dq);
        cmp_q(hq);
        lat = t_first - t_cmd;
        tol = (dly == ALLD) ? 24 : 28;
        if (dly != 0)
            check(16'((lat < dly - tol || lat > dly + tol) ? lat : dly),
                  16'(dly));
        check(16'(busy_o), 16'h0000);
    endtask

    // ********
    // main sequence
    // ********
    initial
    begin
        void'($urandom(59));
        repeat (12) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        @(posedge core_clk_i);
        check({8'h00, slave_addr_o}, 16'h0001);
        wait_q(dq, 10, CYC + 2000);
        build(1'b1, 8'h00, 8'h00);
        cmp_q(dq);
        t_cmd = t_first;
        dq.delete();
        set_dist(16'h0000, 16'hFFFF);
        wait_q(dq, 10, CYC + 200);
        build(1'b1, 8'h00, 8'h00);
        cmp_q(dq);
        check(16'(t_first - t_cmd), 16'(CYC));
        @(posedge core_clk_i);
        bus_mode_i <= 1'b1;
        repeat (CYC) @(posedge core_clk_i);
        check(16'(link.dev_line_oe), 16'h0000);
        check(16'(dq.size()), 16'd10);
        set_dist(16'h03E8, 16'h07D0);
        txn(8'h01, 8'h01, 8'h01, ALLD);
        for (int k = 0; k < 4; k++)
        begin
            set_dist(16'(k), 16'hFFFF);
            txn(8'h01, 8'(16 + k), 8'h01, ONED);
        end
        // second command lands while busy and must vanish
        dq.delete();
        send_cmd(8'h01, 8'h01);
        send_cmd(8'h01, 8'h12);
        build(1'b0, 8'h01, 8'h01);
        wait_q(dq, 14, ALLD + 4000);
        cmp_q(dq);
        na = 8'(8'h02 + $urandom_range(0, 252));
        txn(na, 8'h03, na, ONED);
        check({8'h00, slave_addr_o}, {8'h00, na});
        txn(8'h01, 8'h10, 8'h00, 0);
        txn(na, 8'h13, na, ONED);
        txn(8'hFF, 8'h11, 8'hFF, ONED);
        txn(na, 8'h05, 8'h00, 0);
        complete_run();
    end
endmodule
